/* shared/lpbp_pkg.sv */
// Constants, field layout and state codes of the local processor bus port
// Notes on behaviour
// - Width 11, encoding 1, top lanes 11: burst of four, last held active.
// - Reads match writes except read/write levels and device-driven data.
// - 8-bit bursts step the doubleword after a phase with lanes 3:2 at 11.
// - 16-bit mode: low lane inputs are byte enables or data strobes.
// - 16-bit bursts step the doubleword after a phase with lane 3 high.
// - Latch held active: address taken when strobe and select are active.
// - Otherwise address taken at latch trailing edge; phase still needed.
// - Latch input active level comes from a setup polarity bit.
// - Ready output drives always or tri-states; level is programmable.
// - Tri-state mode drives ready inactive one clock, then floats it.
// - Late release off: read data driven from one clock after address.
// - Late release on: read data held one clock after the final phase.
// - Stretch on, strobe active at end: ready and data held until it drops.
// - Width 11, encoding 0, top lanes 11 wraps at four unless wrap off.
// - Strobe mode bit 0 picks strobe level, 0 low and 1 high.
// - Strobe mode bit 1 picks falling-edge strobe sampling.
// - Ready and select have own falling-edge bits; others sample rising.
// - A falling sample qualifies the next rising edge; address taken then.
// - Read/write style: 00 write high, 01 write low, 1x separate strobes.
// - Width 10: lane inputs are direct enables for all four lanes.
package lpbp_pkg;
  // Register offsets on the setup port
  localparam logic [7:0]  SETUP_OFS  = 8'h00;
  localparam logic [7:0]  STATUS_OFS = 8'h04;
  localparam logic [14:0] SETUP_RST  = 15'h0002;
  // Bit positions inside local_bus_setup
  localparam int WIDTH_LSB   = 0;
  localparam int ENC_BIT     = 2;
  localparam int LATCH_POL   = 3;
  localparam int RDY_POL     = 4;
  localparam int RDY_TRI     = 5;
  localparam int LATE_BIT    = 6;
  localparam int STRETCH_BIT = 7;
  localparam int WRAP_OFF    = 8;
  localparam int AS_POL      = 9;
  localparam int AS_FALL     = 10;
  localparam int RDY_FALL    = 11;
  localparam int SEL_FALL    = 12;
  localparam int RW_LSB      = 13;
  // Codes of port_width_sel and rw_signal_style
  localparam logic [1:0] W8       = 2'h0;
  localparam logic [1:0] W16      = 2'h1;
  localparam logic [1:0] W32      = 2'h2;
  localparam logic [1:0] W32E     = 2'h3;
  localparam logic [1:0] RW_WHIGH = 2'h0;
  localparam logic [1:0] RW_WLOW  = 2'h1;
  // Stepping constants
  localparam logic [1:0]  LINE_END  = 2'h3;
  localparam logic [1:0]  TOP_PAIR  = 2'h3;
  localparam logic [1:0]  LINE_STEP = 2'h1;
  localparam logic [12:0] ADDR_STEP = 13'h0001;
  localparam logic [3:0]  ONE_LANE  = 4'h1;
  // Active-low internal enables, four bits per lane code, code 0 lowest
  localparam logic [63:0] ENC0_MAP = 64'hEC81_EC93_EDB7_EC80;
  localparam logic [63:0] ENC1_MAP = 64'h0000_CC33_EDB7_0000;
  typedef enum logic [1:0] {
    S_IDLE    = 2'b00,
    S_DATA    = 2'b01,
    S_STRETCH = 2'b10,
    S_HOLD    = 2'b11
  } lpbp_state_type;
endpackage : lpbp_pkg

/* src/lpbp_port.sv */
// Local processor bus target port with setup register and memory side
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module lpbp_port (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Setup register port
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [31:0] cfg_wdata,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  output logic      [31:0] cfg_rdata,
  // Local bus control pins
  input  wire logic        strobe_pin,
  input  wire logic        select_n,
  input  wire logic        read_n,
  input  wire logic        write_n,
  input  wire logic        latch_pin,
  input  wire logic [12:0] local_addr,
  input  wire logic [3:0]  byte_lane_inputs,
  input  wire logic        burst_final_n,
  input  wire logic        ready_in_n,
  input  wire logic        ready_in,
  // Ready output pin
  output logic             ready_out,
  output logic             ready_out_oe,
  // Data pins
  input  wire logic [31:0] dq_in,
  output logic      [31:0] dq_out,
  output logic             dq_oe,
  // Shared memory side
  output logic      [12:0] mem_addr,
  input  wire logic [31:0] mem_rdata,
  output logic             mem_wr,
  output logic      [12:0] mem_waddr,
  output logic      [3:0]  mem_be_n,
  output logic      [31:0] mem_wdata
);
  lpbp_pkg::lpbp_state_type state_q, state_d;
  logic [14:0] setup_q;
  logic [31:0] cfg_rdata_q;
  logic [12:0] addr_q, next_addr, ale_addr_q;
  logic        wr_q, burst4_q, wrap_q, line_q, ale_q;
  logic [1:0]  cnt_q;
  logic        strobe_neg_q, select_neg_q, ready_neg_q;
  logic        rdy_act_q, rdy_act_d, rdy_out_q, rdy_oe_q;
  logic        dq_oe_q, dq_oe_d;
  logic [31:0] rd_sel, wr_sel;
  logic        mem_wr_q;
  logic [12:0] mem_waddr_q;
  logic [3:0]  mem_be_n_q, lane_be_n;
  logic [31:0] mem_wdata_q;
  logic [1:0]  width, rw_style;
  logic        strobe_eff, sel_act, phase_done, last, addr_phase;
  logic        wr_now, ale_act, late, stretch, tri_mode, rdy_pol;

  // Setup fields
  assign width    = setup_q[lpbp_pkg::WIDTH_LSB +: 2];
  assign rw_style = setup_q[lpbp_pkg::RW_LSB +: 2];
  assign late     = setup_q[lpbp_pkg::LATE_BIT];
  assign stretch  = setup_q[lpbp_pkg::STRETCH_BIT];
  assign tri_mode = setup_q[lpbp_pkg::RDY_TRI];
  assign rdy_pol  = setup_q[lpbp_pkg::RDY_POL];
  assign ale_act  = latch_pin == setup_q[lpbp_pkg::LATCH_POL];

  // Falling-edge samples, stored as active flags so reset means idle
  always_ff @(negedge ref_clk) begin
    if (rst) begin
      strobe_neg_q <= 1'b0;
      select_neg_q <= 1'b0;
      ready_neg_q  <= 1'b0;
    end else begin
      strobe_neg_q <= strobe_pin == setup_q[lpbp_pkg::AS_POL];
      select_neg_q <= !select_n;
      ready_neg_q  <= !ready_in_n && ready_in;
    end
  end

  // Qualified strobe, select, ready and direction for this rising edge
  always_comb begin
    if (rw_style[1]) begin
      strobe_eff = !read_n || !write_n;
    end else if (setup_q[lpbp_pkg::AS_FALL]) begin
      strobe_eff = strobe_neg_q;
    end else begin
      strobe_eff = strobe_pin == setup_q[lpbp_pkg::AS_POL];
    end
    sel_act = setup_q[lpbp_pkg::SEL_FALL] ? select_neg_q
                                          : !select_n;
    phase_done = setup_q[lpbp_pkg::RDY_FALL] ? ready_neg_q
                 : (!ready_in_n && ready_in);
    if (rw_style == lpbp_pkg::RW_WHIGH) begin
      wr_now = read_n;
    end else if (rw_style == lpbp_pkg::RW_WLOW) begin
      wr_now = !write_n;
    end else begin
      wr_now = !write_n;
    end
  end

  assign addr_phase = state_q == lpbp_pkg::S_IDLE && strobe_eff && sel_act;
  // Burst of four ignores burst_final; others end on it
  assign last = burst4_q ? cnt_q == lpbp_pkg::LINE_END
                         : !burst_final_n;

  // Address stepping after a completed data phase
  always_comb begin
    next_addr = addr_q;
    if (width == lpbp_pkg::W8) begin
      if (byte_lane_inputs[3:2] == lpbp_pkg::TOP_PAIR) begin
        next_addr = addr_q + lpbp_pkg::ADDR_STEP;
      end
    end else if (width == lpbp_pkg::W16) begin
      if (byte_lane_inputs[3]) begin
        next_addr = addr_q + lpbp_pkg::ADDR_STEP;
      end
    end else if (wrap_q) begin
      next_addr = {addr_q[12:2],
                   addr_q[1:0] + lpbp_pkg::LINE_STEP};
    end else begin
      next_addr = addr_q + lpbp_pkg::ADDR_STEP;
    end
  end

  // Lane enables and data steering; top lanes carry low address bits in 8- and 16-bit modes
  always_comb begin
    lane_be_n = byte_lane_inputs;
    wr_sel    = dq_in;
    rd_sel    = mem_rdata;
    if (width == lpbp_pkg::W8) begin
      lane_be_n = ~(lpbp_pkg::ONE_LANE
                    << byte_lane_inputs[3:2]);
      wr_sel = {4{dq_in[7:0]}};
      rd_sel = {24'h00_0000,
                mem_rdata[{byte_lane_inputs[3:2], 3'b000} +: 8]};
    end else if (width == lpbp_pkg::W16) begin
      lane_be_n = byte_lane_inputs[3] ? {byte_lane_inputs[1:0], 2'b11}
                  : {2'b11, byte_lane_inputs[1:0]};
      wr_sel = {2{dq_in[15:0]}};
      rd_sel = {16'h0000, byte_lane_inputs[3] ? mem_rdata[31:16]
                                              : mem_rdata[15:0]};
    end else if (width == lpbp_pkg::W32) begin
      lane_be_n = byte_lane_inputs;
    end else if (line_q) begin
      lane_be_n = 4'h0; // Line transfers move whole doublewords
    end else if (setup_q[lpbp_pkg::ENC_BIT]) begin
      lane_be_n = lpbp_pkg::ENC1_MAP[{byte_lane_inputs, 2'b00} +: 4];
    end else begin
      lane_be_n = lpbp_pkg::ENC0_MAP[{byte_lane_inputs, 2'b00} +: 4];
    end
  end

  // Transfer sequencing; ready and data enable follow the state
  always_comb begin
    state_d   = state_q;
    rdy_act_d = rdy_act_q;
    dq_oe_d   = dq_oe_q;
    case (state_q)
      lpbp_pkg::S_IDLE: begin
        if (addr_phase) begin
          state_d   = lpbp_pkg::S_DATA;
          rdy_act_d = 1'b1;
          dq_oe_d   = !wr_now;
        end
      end
      lpbp_pkg::S_DATA: begin
        if (phase_done && last) begin
          if (stretch && strobe_eff) begin
            state_d = lpbp_pkg::S_STRETCH;
          end else if (!wr_q && late) begin
            state_d   = lpbp_pkg::S_HOLD;
            rdy_act_d = 1'b0;
          end else begin
            state_d   = lpbp_pkg::S_IDLE;
            rdy_act_d = 1'b0;
            dq_oe_d   = 1'b0;
          end
        end
      end
      lpbp_pkg::S_STRETCH: begin
        if (!strobe_eff) begin
          rdy_act_d = 1'b0;
          if (!wr_q && late) begin
            state_d = lpbp_pkg::S_HOLD;
          end else begin
            state_d = lpbp_pkg::S_IDLE;
            dq_oe_d = 1'b0;
          end
        end
      end
      lpbp_pkg::S_HOLD: begin
        state_d = lpbp_pkg::S_IDLE;
        dq_oe_d = 1'b0;
      end
      default: begin
        state_d   = lpbp_pkg::S_IDLE;
        rdy_act_d = 1'b0;
        dq_oe_d   = 1'b0;
      end
    endcase
  end

  // State, ready and data enable registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q   <= lpbp_pkg::S_IDLE;
      rdy_act_q <= 1'b0;
      dq_oe_q   <= 1'b0;
    end else begin
      state_q   <= state_d;
      rdy_act_q <= rdy_act_d;
      dq_oe_q   <= dq_oe_d;
    end
  end

  // Ready pin: driven one clock inactive before floating in tri-state mode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdy_out_q <= 1'b1;
      rdy_oe_q  <= 1'b1;
    end else begin
      rdy_out_q <= rdy_act_d ? rdy_pol : !rdy_pol;
      rdy_oe_q  <= !tri_mode || rdy_act_d || rdy_act_q;
    end
  end

  // Latch trailing edge keeps the address for a later address phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ale_q      <= 1'b0;
      ale_addr_q <= 13'h0000;
    end else begin
      ale_q <= ale_act;
      if (ale_q && !ale_act) begin
        ale_addr_q <= local_addr;
      end
    end
  end

  // Transfer context captured at the address phase, stepped per phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addr_q   <= 13'h0000;
      wr_q     <= 1'b0;
      burst4_q <= 1'b0;
      wrap_q   <= 1'b0;
      line_q   <= 1'b0;
      cnt_q    <= 2'h0;
    end else if (addr_phase) begin
      // Held latch or a same-cycle trailing edge uses the pins directly
      addr_q <= (ale_act || ale_q) ? local_addr
                                   : ale_addr_q;
      wr_q   <= wr_now;
      cnt_q  <= 2'h0;
      line_q <= width == lpbp_pkg::W32E
                && byte_lane_inputs[3:2] == lpbp_pkg::TOP_PAIR;
      burst4_q <= width == lpbp_pkg::W32E && setup_q[lpbp_pkg::ENC_BIT]
                  && byte_lane_inputs[3:2] == lpbp_pkg::TOP_PAIR;
      wrap_q <= width == lpbp_pkg::W32E && !setup_q[lpbp_pkg::ENC_BIT]
                && byte_lane_inputs[3:2] == lpbp_pkg::TOP_PAIR
                && !setup_q[lpbp_pkg::WRAP_OFF];
    end else if (state_q == lpbp_pkg::S_DATA && phase_done) begin
      addr_q <= next_addr;
      cnt_q  <= cnt_q + lpbp_pkg::LINE_STEP;
    end
  end

  // Memory write pulse per completed write phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_wr_q    <= 1'b0;
      mem_waddr_q <= 13'h0000;
      mem_be_n_q  <= 4'hF;
      mem_wdata_q <= 32'h0000_0000;
    end else begin
      mem_wr_q <= state_q == lpbp_pkg::S_DATA && phase_done && wr_q;
      if (state_q == lpbp_pkg::S_DATA && phase_done && wr_q) begin
        mem_waddr_q <= addr_q;
        mem_be_n_q  <= lane_be_n;
        mem_wdata_q <= wr_sel;
      end
    end
  end

  // Setup register write and registered read answer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      setup_q     <= lpbp_pkg::SETUP_RST;
      cfg_rdata_q <= 32'h0000_0000;
    end else begin
      if (cfg_wr && cfg_addr == lpbp_pkg::SETUP_OFS) begin
        setup_q <= cfg_wdata[14:0];
      end
      if (!cfg_rd) begin
        cfg_rdata_q <= 32'h0000_0000;
      end else if (cfg_addr == lpbp_pkg::SETUP_OFS) begin
        cfg_rdata_q <= {17'h0_0000, setup_q};
      end else if (cfg_addr == lpbp_pkg::STATUS_OFS) begin
        cfg_rdata_q <= {14'h0000, state_q, wr_q, cnt_q, addr_q};
      end else begin
        cfg_rdata_q <= 32'h0000_0000; // Unmapped reads answer zero
      end
    end
  end

  // Outputs straight from flops; read data comes from the memory's own path
  assign cfg_rdata    = cfg_rdata_q;
  assign ready_out    = rdy_out_q;
  assign ready_out_oe = rdy_oe_q;
  // A flop here would hand back the previous address for every phase
  assign dq_out       = rd_sel;
  assign dq_oe        = dq_oe_q;
  assign mem_addr     = addr_q;
  assign mem_wr       = mem_wr_q;
  assign mem_waddr    = mem_waddr_q;
  assign mem_be_n     = mem_be_n_q;
  assign mem_wdata    = mem_wdata_q;

  // Checks on the transfer sequence
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_last_done;
    state_q == lpbp_pkg::S_DATA && phase_done && last;
  endsequence
  sequence s_plain_end;
    !(stretch && strobe_eff) && !wr_q;
  endsequence

  property p_burst4_len;
    (state_q == lpbp_pkg::S_DATA && burst4_q && phase_done)
      |=> ((state_q == lpbp_pkg::S_DATA)
           == ($past(cnt_q) != lpbp_pkg::LINE_END));
  endproperty
  a_burst4_len: assert property (p_burst4_len)
    else $error("burst of four did not end after four phases");

  property p_read_drive;
    (addr_phase && !wr_now) |=> dq_oe_q && !wr_q;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("read data not driven after address phase");

  property p_byte_step;
    (state_q == lpbp_pkg::S_DATA && phase_done && width == lpbp_pkg::W8
     && byte_lane_inputs[3:2] != lpbp_pkg::TOP_PAIR)
      |=> addr_q == $past(addr_q);
  endproperty
  a_byte_step: assert property (p_byte_step)
    else $error("8-bit address stepped before last byte");

  property p_half_step;
    (state_q == lpbp_pkg::S_DATA && phase_done && width == lpbp_pkg::W16
     && byte_lane_inputs[3])
      |=> addr_q == $past(addr_q) + lpbp_pkg::ADDR_STEP;
  endproperty
  a_half_step: assert property (p_half_step)
    else $error("16-bit address did not step after upper half");

  property p_latch_held;
    (addr_phase && ale_act) |=> addr_q == $past(local_addr);
  endproperty
  a_latch_held: assert property (p_latch_held)
    else $error("address not captured at address phase");

  property p_tri_release;
    ($fell(rdy_act_q) && tri_mode && $stable(setup_q))
      |-> (rdy_oe_q && rdy_out_q == !rdy_pol)
          ##1 (rdy_act_q || !rdy_oe_q);
  endproperty
  a_tri_release: assert property (p_tri_release)
    else $error("ready not driven inactive for exactly one clock");

  property p_release;
    s_last_done ##0 (s_plain_end and !late) |=> !dq_oe_q;
  endproperty
  a_release: assert property (p_release)
    else $error("read data not released at final phase");

  property p_late_hold;
    s_last_done ##0 (s_plain_end and late) |=> dq_oe_q ##1 !dq_oe_q;
  endproperty
  a_late_hold: assert property (p_late_hold)
    else $error("late release did not hold data one clock");

  property p_stretch;
    (s_last_done ##0 (stretch && strobe_eff))
      |=> (state_q == lpbp_pkg::S_STRETCH && rdy_act_q
           && dq_oe_q == $past(dq_oe_q));
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("ready not stretched while strobe active");

  property p_wrap;
    (state_q == lpbp_pkg::S_DATA && phase_done && wrap_q
     && width == lpbp_pkg::W32E)
      |=> addr_q[12:2] == $past(addr_q[12:2]);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("cache line burst left its line");
endmodule : lpbp_port
`default_nettype wire

/* testbench/lpbp_cpu_model.sv */
// Processor-side master model driving the local bus pins
`timescale 1ns/1ps
`default_nettype none
module lpbp_cpu_model (
  // Clock and option levels
  input  wire logic        ref_clk,
  input  wire logic        as_hi,
  input  wire logic        rdy_hi,
  input  wire logic        lat_lvl,
  input  wire logic [1:0]  rw_style,
  // Device outputs
  input  wire logic        ready_out,
  input  wire logic        ready_out_oe,
  input  wire logic [31:0] dq_out,
  input  wire logic        dq_oe,
  // Local bus pins
  output logic             strobe_pin,
  output logic             select_n,
  output logic             read_n,
  output logic             write_n,
  output logic             latch_pin,
  output logic      [12:0] local_addr,
  output logic      [3:0]  byte_lane_inputs,
  output logic             burst_final_n,
  output logic             ready_in_n,
  output logic             ready_in,
  output logic      [31:0] dq_in
);
  logic [31:0] rdq [0:3];
  logic        tro [0:2];
  logic        too [0:2];
  int          oe_cnt;
  int          rdy_cnt;
  logic        lat_hold;
  // Idle levels from time zero; latch held active by default
  initial begin
    lat_hold = 1'b1;
    strobe_pin = 1'b1;
    select_n = 1'b1;
    read_n = 1'b1;
    write_n = 1'b1;
    latch_pin = 1'b0;
    local_addr = 13'h1fff;
    byte_lane_inputs = 4'hf;
    burst_final_n = 1'b1;
    ready_in_n = 1'b1;
    ready_in = 1'b0;
    dq_in = 32'h5555_aaaa;
  end
  // Write data tagged with start address and phase
  function automatic logic [31:0] wd(input logic [12:0] a, input int i);
    return {3'h0, a, 8'h5a, 8'(i)};
  endfunction : wd
  // One clock; counts cycles of driven data and of active ready
  task automatic tick();
    @(posedge ref_clk);
    oe_cnt += int'(dq_oe === 1'b1);
    rdy_cnt += int'(ready_out === rdy_hi && ready_out_oe === 1'b1);
  endtask : tick
  // Address phase, n data phases, then a released bus for three clocks
  task automatic xfer(input logic rd, input logic [12:0] a,
                      input logic [15:0] lq, input int n,
                      input logic bf_all, input logic hold_s,
                      input logic slow);
    int   i;
    int   k;
    logic wt;
    oe_cnt = 0;
    rdy_cnt = 0;
    @(posedge ref_clk);
    strobe_pin <= as_hi;
    select_n <= 1'b0;
    read_n <= (rw_style == lpbp_pkg::RW_WLOW) | !rd;
    write_n <= (rw_style == lpbp_pkg::RW_WHIGH) | rd;
    latch_pin <= lat_hold ? lat_lvl : !lat_lvl;
    local_addr <= a;
    byte_lane_inputs <= lq[3:0];
    tick();
    for (i = 0; i < n; i++) begin
      wt = slow && (i == 1);
      byte_lane_inputs <= lq[4*i +: 4];
      dq_in <= wd(a, i);
      burst_final_n <= !(bf_all || i == n - 1);
      ready_in_n <= wt;
      ready_in <= !wt;
      if (!hold_s)
        strobe_pin <= !as_hi;
      tick();
      if (wt) begin
        ready_in_n <= 1'b0;
        ready_in <= 1'b1;
        tick();
      end
      rdq[i] = dq_out;
    end
    // Released address and data lines show the inverse, never the last value
    strobe_pin <= !as_hi;
    select_n <= 1'b1;
    read_n <= 1'b1;
    write_n <= 1'b1;
    burst_final_n <= 1'b1;
    ready_in_n <= 1'b1;
    ready_in <= 1'b0;
    local_addr <= ~a;
    dq_in <= ~dq_in;
    for (k = 0; k < 3; k++) begin
      tick();
      tro[k] = ready_out;
      too[k] = ready_out_oe;
    end
  endtask : xfer
  // Latch pulse with the address held past its trailing edge
  task automatic latch_pulse(input logic [12:0] a);
    @(posedge ref_clk);
    latch_pin <= lat_lvl;
    local_addr <= a;
    @(posedge ref_clk);
    latch_pin <= !lat_lvl;
    @(posedge ref_clk);
  endtask : latch_pulse
endmodule : lpbp_cpu_model
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the local processor bus port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        ref_clk, rst, cfg_wr, cfg_rd;
  logic [7:0]  cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, cfgv, dq_in, dq_out, mem_rdata, mem_wdata;
  logic        strobe_pin, select_n, read_n, write_n, latch_pin, ready_in;
  logic        burst_final_n, ready_in_n, ready_out, ready_out_oe, dq_oe;
  logic        mem_wr;
  logic [12:0] local_addr, mem_addr, mem_waddr;
  logic [3:0]  byte_lane_inputs, mem_be_n;
  int          n_fail;
  int          cmp_count;
  int          cyc;
  logic [12:0] wa [$];
  logic [3:0]  wb [$];
  logic [31:0] wd_q [$];
  localparam int LIMIT = 5000;
  // Memory answers with a pattern of the address
  function automatic logic [31:0] pat(input logic [12:0] a);
    return {8'ha5, 11'h000, a};
  endfunction : pat
  assign mem_rdata = pat(mem_addr);
  lpbp_port DUT (
    .ref_clk(ref_clk), .rst(rst), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .strobe_pin(strobe_pin), .select_n(select_n), .read_n(read_n),
    .write_n(write_n), .latch_pin(latch_pin), .local_addr(local_addr),
    .byte_lane_inputs(byte_lane_inputs), .burst_final_n(burst_final_n),
    .ready_in_n(ready_in_n), .ready_in(ready_in), .ready_out(ready_out),
    .ready_out_oe(ready_out_oe), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_wr(mem_wr), .mem_waddr(mem_waddr), .mem_be_n(mem_be_n),
    .mem_wdata(mem_wdata));
  lpbp_cpu_model cpu (
    .ref_clk(ref_clk), .as_hi(cfgv[lpbp_pkg::AS_POL]),
    .rdy_hi(cfgv[lpbp_pkg::RDY_POL]), .lat_lvl(cfgv[lpbp_pkg::LATCH_POL]),
    .rw_style(cfgv[14:13]), .ready_out(ready_out),
    .ready_out_oe(ready_out_oe), .dq_out(dq_out), .dq_oe(dq_oe),
    .strobe_pin(strobe_pin), .select_n(select_n), .read_n(read_n),
    .write_n(write_n), .latch_pin(latch_pin), .local_addr(local_addr),
    .byte_lane_inputs(byte_lane_inputs), .burst_final_n(burst_final_n),
    .ready_in_n(ready_in_n), .ready_in(ready_in), .dq_in(dq_in));
  // Clock of 4 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Log of memory writes, checked after each transfer
  always @(posedge ref_clk) begin
    if (mem_wr === 1'b1) begin
      wa.push_back(mem_waddr);
      wb.push_back(mem_be_n);
      wd_q.push_back(mem_wdata);
    end
  end
  // Cycle ceiling cuts a hang short
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      final_report();
    end
  end
  task automatic final_report();
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cfg_w(input logic [31:0] v);
    @(posedge ref_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= lpbp_pkg::SETUP_OFS;
    cfg_wdata <= v;
    cfgv <= v;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
  endtask : cfg_w
  task automatic cfg_r(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge ref_clk);
    cfg_rd <= 1'b0;
    @(posedge ref_clk);
    chk(cfg_rdata, exp);
  endtask : cfg_r
  // Clearing the log first keeps each transfer judged on its own
  task automatic go(input logic rd, input logic [12:0] a,
                    input logic [15:0] lq, input int n, input logic bf);
    wa.delete();
    wb.delete();
    wd_q.delete();
    cpu.xfer(rd, a, lq, n, bf, cfgv[7], cfgv[0] ^ cfgv[1]);
  endtask : go
  task automatic wexp(input int i, input logic [12:0] a, input logic [3:0] be);
    chk(32'(wa[i]), 32'(a));
    chk(32'(wb[i]), 32'(be));
  endtask : wexp
  // Reset levels, ignored upper setup bits, unmapped read
  task automatic t_reset();
    @(posedge ref_clk);
    chk(32'({ready_out, ready_out_oe, dq_oe, mem_wr, mem_be_n}), 32'h0000_00cf);
    cfg_w(32'hffff_0002);
    cfg_r(lpbp_pkg::SETUP_OFS, 32'h0000_0002);
    cfg_r(8'h08, 32'h0000_0000);
  endtask : t_reset
  // Direct enables with a wait state; reads with late release off and on
  task automatic t_wide();
    int i;
    go(1'b0, 13'h0010, 16'h0050, 3, 1'b0);
    for (i = 0; i < 3; i++) begin
      wexp(i, 13'h0010 + 13'(i), (i == 1) ? 4'h5 : 4'h0);
      chk(wd_q[i], cpu.wd(13'h0010, i));
    end
    cfg_r(lpbp_pkg::STATUS_OFS, 32'h0000_e013);
    for (i = 0; i < 2; i++) begin
      cfg_w(i ? 32'h0000_0042 : 32'h0000_0002);
      go(1'b1, 13'h0020, 16'h0000, 4, 1'b0);
      chk(cpu.rdq[3], pat(13'h0023));
      // Four phases plus the wait state of the second phase
      chk(32'(cpu.oe_cnt), 32'(5 + i));
      chk(32'(cpu.rdy_cnt + wa.size()), 32'h5);
    end
  endtask : t_wide
  // Narrow ports step the doubleword after the top lane code
  task automatic t_narrow();
    int i;
    cfg_w(32'h0000_0000);
    go(1'b0, 13'h0008, 16'h40c8, 4, 1'b0);
    for (i = 0; i < 4; i++)
      wexp(i, 13'h0008 + 13'(i / 2), ~(4'h1 << ((i + 2) % 4)));
    cfg_w(32'h0000_0001);
    go(1'b0, 13'h000c, 16'h0080, 3, 1'b0);
    for (i = 0; i < 3; i++)
      wexp(i, 13'h000c + 13'(i / 2), (i == 1) ? 4'h3 : 4'hc);
  endtask : t_narrow
  // Burst of four ignores the last flag; cache line wraps unless off
  task automatic t_line();
    int i;
    int off;
    cfg_w(32'h0000_0007);
    go(1'b0, 13'h0014, 16'hcccc, 4, 1'b1);
    chk(32'(wa.size()), 32'h4);
    for (i = 0; i < 4; i++)
      wexp(i, 13'h0014 + 13'(i), 4'h0);
    for (off = 0; off < 2; off++) begin
      cfg_w(off ? 32'h0000_0103 : 32'h0000_0003);
      go(1'b0, 13'h0006, 16'hcccc, 4, 1'b0);
      for (i = 0; i < 4; i++)
        wexp(i, off ? 13'h0006 + 13'(i)
                    : 13'h0004 + 13'((i + 2) % 4), 4'h0);
    end
  endtask : t_line
  // Tri-state high-active ready, then stretch held by the strobe
  task automatic t_ready();
    cfg_w(32'h0000_0032);
    go(1'b0, 13'h0030, 16'h0000, 1, 1'b0);
    wexp(0, 13'h0030, 4'h0);
    chk(32'(cpu.rdy_cnt), 32'h1);
    chk(32'({cpu.tro[0], cpu.too[0], cpu.too[1]}), 32'h2);
    cfg_w(32'h0000_0082);
    go(1'b1, 13'h0028, 16'h0000, 2, 1'b0);
    chk(cpu.rdq[1], pat(13'h0029));
    chk(32'(cpu.oe_cnt + 4 * cpu.rdy_cnt), 32'h14);
  endtask : t_ready
  // High strobe, falling sampling, read/write styles, latch edge
  task automatic t_pins();
    int          s;
    logic [12:0] a;
    cfg_w(32'h0000_1e01);
    // 16-bit: upper half first, then the lower half of the next doubleword
    go(1'b0, 13'h0038, 16'h004c, 2, 1'b0);
    wexp(1, 13'h0039, 4'hc);
    chk(wd_q[1], 32'h5a01_5a01);
    for (s = 1; s < 4; s++) begin
      a = 13'h0040 + 13'(s);
      cfg_w(32'h0000_0002 | (32'(s) << lpbp_pkg::RW_LSB));
      go(1'b0, a, 16'h0000, 1, 1'b0);
      chk(wd_q[0], cpu.wd(a, 0));
      go(1'b1, a, 16'h0000, 1, 1'b0);
      chk(cpu.rdq[0], pat(a) + 32'(wa.size()));
    end
    cfg_w(32'h0000_000a);
    cpu.lat_hold = 1'b0;
    cpu.latch_pulse(13'h0050);
    go(1'b0, 13'h0050, 16'h0000, 1, 1'b0);
    wexp(0, 13'h0050, 4'h0);
    cpu.lat_hold = 1'b1;
  endtask : t_pins
  // Main sequence
  initial begin
    rst = 1'b1;
    cfg_addr = 8'h00;
    cfg_wdata = 32'h0000_0000;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfgv = 32'h0000_0002;
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_wide();
    t_narrow();
    t_line();
    t_ready();
    t_pins();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
